// File: include/gtc_pkg.sv
// package: register map, field layout and constants of the gated 16-bit timer/counter
package gtc_pkg;
   // ----------------------------------------------------------------------
   // register offsets (plain port, 8-bit data)
   // ----------------------------------------------------------------------
   localparam logic [3:0] OFS_COUNT_LOW    = 4'h0;
   localparam logic [3:0] OFS_COUNT_HIGH   = 4'h1;
   localparam logic [3:0] OFS_COUNTER_CTRL = 4'h2;
   localparam logic [3:0] OFS_GATE_CTRL    = 4'h3;
   localparam logic [3:0] OFS_STATUS       = 4'h4;

   // ----------------------------------------------------------------------
   // counter_control field positions
   // ----------------------------------------------------------------------
   localparam int CC_ON_BIT     = 0;
   localparam int CC_SYNCB_BIT  = 2;
   localparam int CC_OSCEN_BIT  = 3;
   localparam int CC_PS_LSB     = 4;
   localparam int CC_CS_LSB     = 6;
   localparam logic [7:0] CC_RW_MASK = 8'hfd;

   // ----------------------------------------------------------------------
   // gate_control field positions
   // ----------------------------------------------------------------------
   localparam int GC_GSS_LSB    = 0;
   localparam int GC_POL_BIT    = 6;
   localparam int GC_GE_BIT     = 7;
   localparam logic [7:0] GC_RW_MASK = 8'hc3;

   // status: bit 0 overflow flag (write 1 clears), bit 1 secondary osc running
   localparam int ST_OVF_BIT    = 0;
   localparam int ST_OSC_BIT    = 1;

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0]  RST_CTRL  = 8'h00;
   localparam logic [7:0]  RST_GATE  = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;

   // ----------------------------------------------------------------------
   // clock select and gate source encodings
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      CS_INSTR  = 2'b00,
      CS_SYSTEM = 2'b01,
      CS_EXT    = 2'b10,
      CS_LFOSC  = 2'b11
   } gtc_clk_sel_t;

   typedef enum logic [1:0] {
      GS_PIN      = 2'b00,
      GS_T8_OVF   = 2'b01,
      GS_PERIOD   = 2'b10,
      GS_RESERVED = 2'b11
   } gtc_gate_src_t;

   // instruction clock is system clock / 4
   localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;
   localparam logic [15:0] SYS_STEP       = 16'h0004;
   localparam logic [15:0] UNIT_STEP      = 16'h0001;
endpackage

// File: hw/gtc_edge_sync.sv
// two-stage synchroniser with rising and falling edge detection
`timescale 1ns/10ps
module gtc_edge_sync (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic arst_n,
   input  wire logic clk_en,
   // asynchronous level in
   input  wire logic async_in,
   // synchronised level and edges
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta;
   logic sync;
   logic prev;

   // first stage feeds only the second stage
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else if (clk_en) begin
         meta <= async_in;
         sync <= meta;
         prev <= sync;
      end
   end

   assign level = sync;
   assign rise  = sync & ~prev;
   assign fall  = ~sync & prev;
endmodule

// File: hw/gtc_timer.sv
// gated 16-bit timer/counter with prescaler, clock select and gate polarity
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module gtc_timer
   import gtc_pkg::*;
(
   // clock, reset, enable
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic       clk_en,
   // register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // clock sources
   input  wire logic       external_clock_pin,
   input  wire logic       secondary_osc_in,
   input  wire logic       low_freq_internal_osc,
   // gate sources
   input  wire logic       gate_pin,
   input  wire logic       t8_overflow_pulse,
   input  wire logic       period_match_pulse,
   // oscillator and status outputs
   output logic            secondary_osc_out,
   output logic            secondary_osc_run,
   output logic            overflow_flag,
   output logic            wake_request
);
   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic [7:0]  counter_control;
   logic [7:0]  gate_control;
   logic [15:0] count;
   logic [2:0]  prescale_cnt;
   logic [1:0]  instr_phase;
   logic        armed;
   logic        ovf_hold;

   logic        ext_level;
   logic        ext_rise;
   logic        ext_fall;
   logic        osc_level;
   logic        osc_rise;
   logic        osc_fall;
   logic        lf_rise;
   logic        gpin_level;

   // ----------------------------------------------------------------------
   // decoded fields
   // ----------------------------------------------------------------------
   logic         counter_on;
   logic         sync_bypass;
   logic         secondary_osc_enable;
   logic [1:0]   prescale_select;
   gtc_clk_sel_t clock_select;
   gtc_gate_src_t gate_source_select;
   logic         gate_polarity;
   logic         gate_enable;

   assign counter_on           = counter_control[CC_ON_BIT];
   assign sync_bypass          = counter_control[CC_SYNCB_BIT];
   assign secondary_osc_enable = counter_control[CC_OSCEN_BIT];
   assign prescale_select      = counter_control[CC_PS_LSB +: 2];
   assign clock_select         = gtc_clk_sel_t'(counter_control[CC_CS_LSB +: 2]);
   assign gate_source_select   = gtc_gate_src_t'(gate_control[GC_GSS_LSB +: 2]);
   assign gate_polarity        = gate_control[GC_POL_BIT];
   assign gate_enable          = gate_control[GC_GE_BIT];

   // byte write detect, used for prescaler clear, arming clear and overflow suppression
   function automatic logic is_count_write(input logic wr, input logic [3:0] a);
      is_count_write = wr && (a == OFS_COUNT_LOW || a == OFS_COUNT_HIGH);
   endfunction

   logic count_wr;
   assign count_wr = is_count_write(reg_wr, reg_addr);

   // ----------------------------------------------------------------------
   // synchronisers for every pin and foreign clock
   // ----------------------------------------------------------------------
   gtc_edge_sync u_ext (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .clk_en   (clk_en),
      .async_in (external_clock_pin),
      .level    (ext_level),
      .rise     (ext_rise),
      .fall     (ext_fall)
   );

   gtc_edge_sync u_osc (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .clk_en   (clk_en),
      .async_in (secondary_osc_in),
      .level    (osc_level),
      .rise     (osc_rise),
      .fall     (osc_fall)
   );

   gtc_edge_sync u_lf (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .clk_en   (clk_en),
      .async_in (low_freq_internal_osc),
      .level    (),
      .rise     (lf_rise),
      .fall     ()
   );

   gtc_edge_sync u_gate (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .clk_en   (clk_en),
      .async_in (gate_pin),
      .level    (gpin_level),
      .rise     (),
      .fall     ()
   );

   // ----------------------------------------------------------------------
   // secondary oscillator: inverting amplifier stand-in, gated by enable
   // ----------------------------------------------------------------------
   // the core holds no sleep state, so the enable alone keeps it running
   assign secondary_osc_out = secondary_osc_enable & ~secondary_osc_in;
   assign secondary_osc_run = secondary_osc_enable;

   // ----------------------------------------------------------------------
   // instruction phase: one instruction cycle per four system clocks
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         instr_phase <= 2'h0;
      end else if (clk_en) begin
         instr_phase <= instr_phase + 2'h1;
      end
   end

   // ----------------------------------------------------------------------
   // clock source tick selection
   // ----------------------------------------------------------------------
   logic src_tick;
   logic pin_rise;
   logic pin_fall;
   logic ext_mode;

   // secondary oscillator replaces the pin when its enable is set
   assign pin_rise = secondary_osc_enable ? osc_rise : ext_rise;
   assign pin_fall = secondary_osc_enable ? osc_fall : ext_fall;
   assign ext_mode = (clock_select == CS_EXT);

   always_comb begin
      case (clock_select)
         CS_INSTR:  src_tick = (instr_phase == INSTR_DIV_LAST);
         CS_SYSTEM: src_tick = (instr_phase == INSTR_DIV_LAST);  // four per cycle, see step
         CS_EXT:    src_tick = pin_rise & armed;
         default:   src_tick = lf_rise;
      endcase
   end

   // ----------------------------------------------------------------------
   // gate source and enable
   // ----------------------------------------------------------------------
   logic gate_src;
   logic run;

   always_comb begin
      case (gate_source_select)
         GS_PIN:    gate_src = gpin_level;
         GS_T8_OVF: gate_src = t8_overflow_pulse;
         GS_PERIOD: gate_src = period_match_pulse;
         default:   gate_src = 1'b0;
      endcase
   end

   // off, always on, or gated by level matching polarity
   assign run = counter_on && (!gate_enable || (gate_src == gate_polarity));

   // ----------------------------------------------------------------------
   // counter-mode arming: a falling edge must be seen first
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         armed <= 1'b0;
      end else if (clk_en) begin
         if (!counter_on || count_wr) begin
            armed <= 1'b0;
         end else if (pin_fall) begin
            armed <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // prescaler: hidden, cleared by any counter byte write
   // ----------------------------------------------------------------------
   logic pre_tick;
   logic [2:0] pre_last;

   assign pre_last = 3'((4'h1 << prescale_select) - 4'h1);
   assign pre_tick = src_tick && run && (prescale_cnt == pre_last);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prescale_cnt <= 3'h0;
      end else if (clk_en) begin
         if (count_wr) begin
            prescale_cnt <= 3'h0;
         end else if (src_tick && run) begin
            prescale_cnt <= (prescale_cnt >= pre_last) ? 3'h0 : prescale_cnt + 3'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // 16-bit count; byte writes override an increment in the same cycle
   // ----------------------------------------------------------------------
   logic [15:0] step;
   logic [16:0] next_sum;
   logic        rollover;

   assign step     = (clock_select == CS_SYSTEM) ? SYS_STEP : UNIT_STEP;
   assign next_sum = {1'b0, count} + {1'b0, step};
   assign rollover = pre_tick && !count_wr && next_sum[16];

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= RST_COUNT;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == OFS_COUNT_LOW) begin
            count[7:0] <= reg_wdata;
         end else if (reg_wr && reg_addr == OFS_COUNT_HIGH) begin
            count[15:8] <= reg_wdata;
         end else if (pre_tick) begin
            count <= next_sum[15:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // overflow flag: set wins over software clear
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ovf_hold <= 1'b0;
      end else if (clk_en) begin
         if (rollover) begin
            ovf_hold <= 1'b1;
         end else if (reg_wr && reg_addr == OFS_STATUS && reg_wdata[ST_OVF_BIT]) begin
            ovf_hold <= 1'b0;
         end
      end
   end

   assign overflow_flag = ovf_hold;
   // only async external counting may wake a sleeping core
   assign wake_request  = ovf_hold && sync_bypass && ext_mode;

   // ----------------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         counter_control <= RST_CTRL;
         gate_control    <= RST_GATE;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == OFS_COUNTER_CTRL) begin
            counter_control <= reg_wdata & CC_RW_MASK;
         end else if (reg_addr == OFS_GATE_CTRL) begin
            gate_control <= reg_wdata & GC_RW_MASK;
         end
      end
   end

   // ----------------------------------------------------------------------
   // read data, one cycle after the strobe
   // ----------------------------------------------------------------------
   // count is a single-clock register, so each byte read is stable
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         if (!reg_rd) begin
            reg_rdata <= 8'h00;
         end else if (reg_addr == OFS_COUNT_LOW) begin
            reg_rdata <= count[7:0];
         end else if (reg_addr == OFS_COUNT_HIGH) begin
            reg_rdata <= count[15:8];
         end else if (reg_addr == OFS_COUNTER_CTRL) begin
            reg_rdata <= counter_control;
         end else if (reg_addr == OFS_GATE_CTRL) begin
            reg_rdata <= gate_control;
         end else if (reg_addr == OFS_STATUS) begin
            reg_rdata <= {6'h00, secondary_osc_enable, ovf_hold};
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // sync_bypass only selects wake behaviour here: all pin and oscillator counting is sampled
   // through synchronisers, so a mode switch neither skips nor adds counts
endmodule

// File: sim/gtc_timer_sva.sv
// checker: port-level properties of the gated timer/counter
`timescale 1ns/10ps
module gtc_timer_sva
   import gtc_pkg::*;
(
   // clock, reset, enable
   input logic       core_clk,
   input logic       arst_n,
   input logic       clk_en,
   // register port
   input logic [3:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic       reg_wr,
   input logic       reg_rd,
   input logic [7:0] reg_rdata,
   // oscillator and status
   input logic       secondary_osc_in,
   input logic       secondary_osc_out,
   input logic       secondary_osc_run,
   input logic       overflow_flag,
   input logic       wake_request
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_unmapped; reg_rd && reg_addr > OFS_STATUS |=> reg_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_ctrl_rb; reg_wr && reg_addr == OFS_COUNTER_CTRL ##1 reg_rd && reg_addr == OFS_COUNTER_CTRL
      |=> reg_rdata == ($past(reg_wdata, 2) & CC_RW_MASK); endproperty
   a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
   property p_gate_rb; reg_wr && reg_addr == OFS_GATE_CTRL ##1 reg_rd && reg_addr == OFS_GATE_CTRL
      |=> reg_rdata == ($past(reg_wdata, 2) & GC_RW_MASK); endproperty
   a_gate_rb: assert property (p_gate_rb) else $error("gate readback wrong");
   // ---------------------------------------------------------------
   // oscillator, flag, wake
   // ---------------------------------------------------------------
   property p_osc_run; reg_wr && reg_addr == OFS_COUNTER_CTRL |=> secondary_osc_run == $past(reg_wdata[CC_OSCEN_BIT]);
   endproperty
   a_osc_run: assert property (p_osc_run) else $error("osc enable not applied");
   property p_osc_out; secondary_osc_out == (secondary_osc_run && !secondary_osc_in); endproperty
   a_osc_out: assert property (p_osc_out) else $error("osc drive wrong");
   // sticky unless software writes one to the flag bit
   property p_flag_hold; $past(overflow_flag) && !$past(reg_wr && reg_addr == OFS_STATUS && reg_wdata[ST_OVF_BIT])
      |-> overflow_flag; endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("overflow flag dropped");
   property p_status_rd; reg_rd && reg_addr == OFS_STATUS
      |=> reg_rdata == {6'h00, $past(secondary_osc_run), $past(overflow_flag)}; endproperty
   a_status_rd: assert property (p_status_rd) else $error("status read wrong");
   property p_wake; wake_request |-> overflow_flag; endproperty
   a_wake: assert property (p_wake) else $error("wake without overflow");
endmodule
bind gtc_timer gtc_timer_sva i_sva (.core_clk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .secondary_osc_in, .secondary_osc_out, .secondary_osc_run, .overflow_flag, .wake_request);

// File: sim/gtc_far_end.sv
// far-side model: external clock pin bursts, crystal oscillator, internal slow oscillator
`timescale 1ns/10ps
module gtc_far_end (
   // clock and burst request
   input  wire logic       core_clk,
   input  wire logic       burst_go,
   input  wire logic [3:0] burst_len,
   input  wire logic       secondary_osc_run,
   // clock sources
   output logic            external_clock_pin = 1'b0,
   output logic            secondary_osc_in = 1'b0,
   output logic            low_freq_internal_osc = 1'b0,
   output logic            burst_busy
);
   logic [2:0] div = 3'h0;
   logic [4:0] half = 5'h00;
   assign burst_busy = (half != 5'h00);
   // half period of 8 clocks; pin rests low between bursts so no stray edge
   always @(posedge core_clk) begin
      div <= div + 3'h1;
      if (div == 3'h7) begin
         low_freq_internal_osc <= !low_freq_internal_osc;
         secondary_osc_in <= secondary_osc_run ? !secondary_osc_in : 1'b0;
         if (half != 5'h00) begin
            external_clock_pin <= !external_clock_pin;
            half <= half - 5'h01;
         end
      end
      if (burst_go) half <= {burst_len, 1'b0};
   end
endmodule

// File: sim/tb_top.sv
// testbench: register access, clock sources, prescaler, gate, overflow, external counting
`timescale 1ns/10ps
module tb_top
   import gtc_pkg::*;
;
   logic       core_clk = 1'b0;
   logic       arst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       clk_en = 1'b1;
   logic [7:0] reg_rdata;
   logic       gate_pin = 1'b0;
   logic       t8_ovf = 1'b0;
   logic       per_match = 1'b0;
   logic       burst_go = 1'b0;
   logic [3:0] burst_len = 4'h0;
   logic       ext_pin, sosc_in, sosc_out, sosc_run, lfosc, burst_busy, overflow_flag, wake_request;
   int         miscompares = 0;
   int         tests_run = 0;
   logic [7:0] d;
   // 10 MHz clock
   always #50 core_clk = !core_clk;
   gtc_timer i_dut (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .external_clock_pin(ext_pin), .secondary_osc_in(sosc_in), .low_freq_internal_osc(lfosc),
      .gate_pin(gate_pin), .t8_overflow_pulse(t8_ovf), .period_match_pulse(per_match),
      .secondary_osc_out(sosc_out), .secondary_osc_run(sosc_run), .overflow_flag(overflow_flag),
      .wake_request(wake_request));
   gtc_far_end i_far (.core_clk(core_clk), .burst_go(burst_go), .burst_len(burst_len),
      .secondary_osc_run(sosc_run), .external_clock_pin(ext_pin), .secondary_osc_in(sosc_in),
      .low_freq_internal_osc(lfosc), .burst_busy(burst_busy));
   // ---------------------------------------------------------------
   // bus and compare tasks
   // ---------------------------------------------------------------
   task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   // small #1 keeps a following strobe out of this time step
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // count gain of the low byte over exactly 64 clocks, so every source phase gives
   // a whole number of ticks; 24 clocks of run-in let counter mode see its falling edge
   task automatic meas(input logic [7:0] cc, input logic [7:0] gc, input logic [7:0] ex);
      logic [7:0] a;
      logic [7:0] b;
      wr(OFS_GATE_CTRL, gc);
      wr(OFS_COUNTER_CTRL, cc & 8'hfe);
      repeat (20) @(posedge core_clk);
      wr(OFS_COUNTER_CTRL, cc);
      repeat (24) @(posedge core_clk);
      rd(OFS_COUNT_LOW, a);
      repeat (63) @(posedge core_clk);
      rd(OFS_COUNT_LOW, b);
      cmp("count gain", ex, b - a);
   endtask
   // clock enable low freezes count and phase: 64 live edges remain in the window
   task automatic t_freeze;
      logic [7:0] a;
      logic [7:0] b;
      wr(OFS_GATE_CTRL, 8'h00);
      wr(OFS_COUNTER_CTRL, 8'h01);
      repeat (8) @(posedge core_clk);
      rd(OFS_COUNT_LOW, a);
      @(posedge core_clk);
      clk_en <= 1'b0;
      repeat (64) @(posedge core_clk);
      clk_en <= 1'b1;
      repeat (62) @(posedge core_clk);
      rd(OFS_COUNT_LOW, b);
      cmp("frozen gain", 8'd16, b - a);
   endtask
   task automatic burst(input logic [3:0] n);
      burst_go <= 1'b1;
      burst_len <= n;
      @(posedge core_clk);
      burst_go <= 1'b0;
      #1;
      for (int i = 0; i < 400 && burst_busy; i++) @(posedge core_clk);
      if (burst_busy) begin
         miscompares++;
         results();
      end
      repeat (10) @(posedge core_clk);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      for (int i = 0; i < 6; i++) begin
         rd(4'(i), d);
         cmp("reset value", 8'h00, d);
      end
      wr(OFS_COUNTER_CTRL, 8'hfe);
      rd(OFS_COUNTER_CTRL, d);
      cmp("control", 8'hfc, d);
      wr(OFS_GATE_CTRL, 8'hff);
      rd(OFS_GATE_CTRL, d);
      cmp("gate control", 8'hc3, d);
      wr(4'h5, 8'hff);
      rd(4'h5, d);
      cmp("unmapped", 8'h00, d);
      wr(OFS_GATE_CTRL, 8'h00);
      wr(OFS_COUNTER_CTRL, 8'h00);
   endtask
   task automatic t_ovf;
      wr(OFS_STATUS, 8'h01);
      wr(OFS_COUNT_HIGH, 8'hff);
      wr(OFS_COUNT_LOW, 8'hfe);
      cmp("flag idle", 8'h00, {7'h00, overflow_flag});
      wr(OFS_COUNTER_CTRL, 8'h01);
      repeat (20) @(posedge core_clk);
      cmp("flag set", 8'h01, {7'h00, overflow_flag});
      rd(OFS_STATUS, d);
      cmp("status", 8'h01, d);
      rd(OFS_COUNT_HIGH, d);
      cmp("high after wrap", 8'h00, d);
      wr(OFS_STATUS, 8'h01);
      cmp("flag cleared", 8'h00, {7'h00, overflow_flag});
   endtask
   // prescale 8 running, then a write restarts the prescaler
   task automatic t_write;
      wr(OFS_COUNTER_CTRL, 8'h31);
      repeat (50) @(posedge core_clk);
      wr(OFS_COUNT_LOW, 8'h10);
      rd(OFS_COUNT_LOW, d);
      cmp("live write", 8'h10, d);
      repeat (26) @(posedge core_clk);
      rd(OFS_COUNT_LOW, d);
      cmp("prescaler cleared", 8'h10, d);
      repeat (10) @(posedge core_clk);
      rd(OFS_COUNT_LOW, d);
      cmp("first increment", 8'h11, d);
   endtask
   task automatic t_rates;
      logic [7:0] rc [8];
      logic [7:0] re [8];
      rc = '{8'h00, 8'h01, 8'h41, 8'h11, 8'h21, 8'h31, 8'h89, 8'hc1};
      re = '{8'd0, 8'd16, 8'd64, 8'd8, 8'd4, 8'd2, 8'd4, 8'd4};
      for (int i = 0; i < 8; i++) meas(rc[i], 8'h00, re[i]);
      cmp("osc running", 8'h00, {7'h00, sosc_run});
   endtask
   // selected source alone decides; the others sit at the opposite level;
   // the reserved source reads as low
   task automatic t_gate;
      for (int p = 0; p < 2; p++)
         for (int l = 0; l < 2; l++)
            for (int g = 0; g < 4; g++) begin
               gate_pin <= (g == 0) ? l[0] : !l[0];
               t8_ovf <= (g == 1) ? l[0] : !l[0];
               per_match <= (g == 2) ? l[0] : !l[0];
               meas(8'h01, {1'b1, p[0], 4'h0, 2'(g)},
                  (g == 3) ? ((p == 0) ? 8'd16 : 8'd0) : ((l == p) ? 8'd16 : 8'd0));
            end
      gate_pin <= 1'b1;
      meas(8'h01, 8'h00, 8'd16);
   endtask
   // pin idles low, so the first rising edge after the write is not counted
   task automatic t_ext;
      wr(OFS_COUNTER_CTRL, 8'h80);
      wr(OFS_COUNT_LOW, 8'h00);
      wr(OFS_COUNT_HIGH, 8'h00);
      wr(OFS_COUNTER_CTRL, 8'h81);
      burst(4'd5);
      rd(OFS_COUNT_LOW, d);
      cmp("ext count", 8'd4, d);
      wr(OFS_COUNTER_CTRL, 8'h85);
      burst(4'd3);
      rd(OFS_COUNT_LOW, d);
      cmp("bypass count", 8'd7, d);
      cmp("no wake", 8'h00, {7'h00, wake_request});
      // stop before loading in bypass mode; second rising edge wraps the count
      wr(OFS_COUNTER_CTRL, 8'h84);
      wr(OFS_COUNT_HIGH, 8'hff);
      wr(OFS_COUNT_LOW, 8'hff);
      wr(OFS_COUNTER_CTRL, 8'h85);
      burst(4'd2);
      cmp("wake", 8'h01, {7'h00, wake_request});
      wr(OFS_COUNTER_CTRL, 8'h81);
      cmp("sync no wake", 8'h00, {7'h00, wake_request});
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      t_regs();
      t_ovf();
      t_write();
      t_rates();
      t_gate();
      t_freeze();
      t_ext();
      results();
   end
endmodule
